/* rtl/sas_conv_timer.sv */
module sas_conv_timer (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    // control
    input  wire logic       start,
    input  wire logic       abort,
    input  wire logic [2:0] timeCode,
    // status
    output logic            done,
    output logic            running
);
    logic [10:0] cnt_reg;
    logic [10:0] cnt_next;
    logic        run_reg;
    logic        run_next;

    always_comb begin
        cnt_next = cnt_reg;
        run_next = run_reg;
        if (abort) begin
            run_next = 1'b0;
            cnt_next = sas_pkg::CNT_ZERO;
        end else if (start) begin
            run_next = 1'b1;
            cnt_next = sas_pkg::conv_cycles(timeCode);
        end else if (run_reg) begin
            cnt_next = cnt_reg - sas_pkg::CNT_ONE;
            if (cnt_reg == sas_pkg::CNT_ONE) begin
                run_next = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cnt_reg <= sas_pkg::CNT_ZERO;
            run_reg <= 1'b0;
        end else if (clkEn) begin
            cnt_reg <= cnt_next;
            run_reg <= run_next;
        end
    end

    assign done    = run_reg && (cnt_reg == sas_pkg::CNT_ONE) && !abort;
    assign running = run_reg;

    logic [10:0] elapsed_reg;
    logic [10:0] want_reg;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            elapsed_reg <= sas_pkg::CNT_ZERO;
            want_reg    <= sas_pkg::CNT_ZERO;
        end else if (clkEn) begin
            if (start) begin
                elapsed_reg <= sas_pkg::CNT_ZERO;
                want_reg    <= sas_pkg::conv_cycles(timeCode) - sas_pkg::CNT_ONE;
            end else if (run_reg) begin
                elapsed_reg <= elapsed_reg + sas_pkg::CNT_ONE;
            end
        end
    end

    property p_conv_len;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        done |-> elapsed_reg == want_reg;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");
endmodule : sas_conv_timer

/* rtl/sas_pkg.sv */
package sas_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL1  = 8'h34;
    localparam logic [7:0] ADDR_STATUS = 8'h35;
    localparam logic [7:0] ADDR_RES_LO = 8'h36;
    localparam logic [7:0] ADDR_RES_HI = 8'h37;
    // field positions
    localparam int START_BIT = 7;
    localparam int MODE_HI   = 6;
    localparam int MODE_LO   = 5;
    localparam int AIN_BIT   = 4;
    localparam int CHAN_HI   = 3;
    localparam int DONE_BIT  = 7;
    localparam int BUSY_BIT  = 6;
    localparam int TIME_HI   = 2;
    localparam int RESH_HI   = 1;
    // reset values
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [9:0] RES_ZERO  = 10'h000;
    // operating modes
    localparam logic [1:0] MODE_OFF    = 2'h0;
    localparam logic [1:0] MODE_SINGLE = 2'h1;
    localparam logic [1:0] MODE_REPEAT = 2'h3;
    // conversion length in clock periods
    localparam logic [10:0] CONV_39   = 11'h027;
    localparam logic [10:0] CONV_78   = 11'h04E;
    localparam logic [10:0] CONV_156  = 11'h09C;
    localparam logic [10:0] CONV_312  = 11'h138;
    localparam logic [10:0] CONV_624  = 11'h270;
    localparam logic [10:0] CONV_1248 = 11'h4E0;
    localparam logic [10:0] CNT_ONE   = 11'h001;
    localparam logic [10:0] CNT_ZERO  = 11'h000;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CONV  = 3'b010,
        ST_STORE = 3'b100
    } sas_state_t;

    // reserved codes run the longest length
    function automatic logic [10:0] conv_cycles(input logic [2:0] code);
        case (code)
            3'h0:    conv_cycles = CONV_39;
            3'h1:    conv_cycles = CONV_78;
            3'h2:    conv_cycles = CONV_156;
            3'h3:    conv_cycles = CONV_312;
            3'h4:    conv_cycles = CONV_624;
            default: conv_cycles = CONV_1248;
        endcase
    endfunction : conv_cycles
endpackage : sas_pkg

/* rtl/sas_result_store.sv */
module sas_result_store (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    // control
    input  wire logic       clear,
    input  wire logic       storeReq,
    input  wire logic [9:0] sampleIn,
    input  wire logic       rdLow,
    input  wire logic       rdHigh,
    // results
    output logic [9:0]      result,
    output logic            stored
);
    logic [9:0] res_reg;
    logic [9:0] res_next;
    logic       lowPend_reg;
    logic       lowPend_next;

    assign stored = storeReq && !lowPend_reg && !clear;

    always_comb begin
        res_next     = res_reg;
        lowPend_next = lowPend_reg;
        if (clear) begin
            res_next     = sas_pkg::RES_ZERO;
            lowPend_next = 1'b0;
        end else begin
            if (stored) begin
                res_next = sampleIn;
            end
            if (rdLow) begin
                lowPend_next = 1'b1;
            end else if (rdHigh) begin
                lowPend_next = 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            res_reg     <= sas_pkg::RES_ZERO;
            lowPend_reg <= 1'b0;
        end else if (clkEn) begin
            res_reg     <= res_next;
            lowPend_reg <= lowPend_next;
        end
    end

    assign result = res_reg;

    property p_keep_old;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        (storeReq && lowPend_reg && !clear) |=> $stable(res_reg);
    endproperty
    a_keep_old: assert property (p_keep_old) else $error("result overwritten mid-read");
endmodule : sas_result_store

/* rtl/sas_sequencer.sv */
// Notes on behaviour
// - time code 000..101 gives 39..1248 clock periods; 110, 111 reserved.
// - done flag reads 0 before and during conversion, 1 after result stored; in mode 11 it stays 1 through later conversions until an upper read.
// - busy flag sets when conversion starts, clears on finish or forced stop.
// - status register bits 3, 4 and 5 read as zero.
// - low-power entry clears done, busy and both result registers.
// - reading the upper result register clears the done flag.
// - new single start without upper read clears the done flag.
// - start latency stays within 10 clock periods.
// - result bits 7..0 in low register, bits 9..8 in upper bits 1..0.
// - writing mode off clears both result registers.
// - repeat completion between low and high reads keeps old result, no interrupt.
// - mode 01 plus start bit runs one conversion; start bit self-clears.
// - completion stores result, sets done and raises the completion interrupt.
// - mode 11 plus start converts repeatedly, restarting after each completion.
// - writing mode off halts conversion at once, stores nothing, clears busy.
// - control register 0x34: start 7, mode 6:5, input enable 4, channel 3:0.
// - writing mode off also clears done and busy flags.
module sas_sequencer (
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       clkEn,
    // register port
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWrData,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic [7:0]      regRdData,
    // power management
    input  wire logic       lowPowerEnter,
    // analog front end
    input  wire logic [9:0] sampleIn,
    output logic [3:0]      channelSelect,
    output logic            analogInputEnable,
    output logic            convActive,
    // interrupt
    output logic            conversionCompleteIrq
);
    localparam int LAT_MAX = 10;

    // control register
    logic       startBit_reg;
    logic       startBit_next;
    logic [1:0] mode_reg;
    logic [1:0] mode_next;
    logic       analog_input_enable_reg;
    logic       analog_input_enable_next;
    logic [3:0] chan_reg;
    logic [3:0] chan_next;
    // status register
    logic [2:0] timeCode_reg;
    logic [2:0] timeCode_next;
    logic       done_reg;
    logic       done_next;
    // sequencer
    sas_pkg::sas_state_t state_reg;
    sas_pkg::sas_state_t state_next;
    logic       irq_reg;
    logic       irq_next;
    logic [7:0] rdData_reg;
    logic [7:0] rdData_next;

    logic       wrCtrl;
    logic       wrStatus;
    logic       rdLow;
    logic       rdHigh;
    logic       modeOffWr;
    logic       clearAll;
    logic       modeValid;
    logic       goStart;
    logic       timerStart;
    logic       timerDone;
    logic       storeReq;
    logic       stored;
    logic       busy;
    logic [9:0] result;

    assign wrCtrl    = regWr && (regAddr == sas_pkg::ADDR_CTRL1);
    assign wrStatus  = regWr && (regAddr == sas_pkg::ADDR_STATUS);
    assign rdLow     = regRd && (regAddr == sas_pkg::ADDR_RES_LO);
    assign rdHigh    = regRd && (regAddr == sas_pkg::ADDR_RES_HI);
    assign modeOffWr = wrCtrl && (regWrData[sas_pkg::MODE_HI:sas_pkg::MODE_LO] == sas_pkg::MODE_OFF);
    assign clearAll  = lowPowerEnter || modeOffWr;
    assign modeValid = (mode_reg == sas_pkg::MODE_SINGLE) || (mode_reg == sas_pkg::MODE_REPEAT);
    assign goStart   = (state_reg == sas_pkg::ST_IDLE) && startBit_reg && modeValid && !clearAll;
    assign storeReq  = (state_reg == sas_pkg::ST_STORE) && !clearAll;
    assign busy      = (state_reg != sas_pkg::ST_IDLE);
    assign timerStart = goStart || (storeReq && (mode_reg == sas_pkg::MODE_REPEAT));

    sas_conv_timer u_timer (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .start    (timerStart),
        .abort    (clearAll),
        .timeCode (timeCode_reg),
        .done     (timerDone),
        .running  ()
    );

    sas_result_store u_result (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .clkEn    (clkEn),
        .clear    (clearAll),
        .storeReq (storeReq),
        .sampleIn (sampleIn),
        .rdLow    (rdLow),
        .rdHigh   (rdHigh),
        .result   (result),
        .stored   (stored)
    );

    // control and status fields
    always_comb begin
        startBit_next = startBit_reg;
        mode_next     = mode_reg;
        analog_input_enable_next    = analog_input_enable_reg;
        chan_next     = chan_reg;
        timeCode_next = timeCode_reg;
        done_next     = done_reg;
        if (lowPowerEnter) begin
            startBit_next = 1'b0;
            mode_next     = sas_pkg::MODE_OFF;
            analog_input_enable_next    = 1'b0;
        end else if (wrCtrl) begin
            startBit_next = regWrData[sas_pkg::START_BIT];
            mode_next     = regWrData[sas_pkg::MODE_HI:sas_pkg::MODE_LO];
            analog_input_enable_next    = regWrData[sas_pkg::AIN_BIT];
            chan_next     = regWrData[sas_pkg::CHAN_HI:0];
        end else if (state_reg == sas_pkg::ST_IDLE) begin
            startBit_next = 1'b0;
        end
        if (wrStatus) begin
            timeCode_next = regWrData[sas_pkg::TIME_HI:0];
        end
        if (clearAll) begin
            done_next = 1'b0;
        end else if (stored) begin
            done_next = 1'b1;
        end else if (rdHigh || (goStart && mode_reg == sas_pkg::MODE_SINGLE)) begin
            done_next = 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            startBit_reg <= 1'b0;
            mode_reg     <= sas_pkg::MODE_OFF;
            analog_input_enable_reg    <= 1'b0;
            chan_reg     <= 4'h0;
            timeCode_reg <= 3'h0;
            done_reg     <= 1'b0;
        end else if (clkEn) begin
            startBit_reg <= startBit_next;
            mode_reg     <= mode_next;
            analog_input_enable_reg    <= analog_input_enable_next;
            chan_reg     <= chan_next;
            timeCode_reg <= timeCode_next;
            done_reg     <= done_next;
        end
    end

    // sequencer states
    always_comb begin
        state_next = state_reg;
        irq_next   = 1'b0;
        unique case (state_reg)
            sas_pkg::ST_IDLE: begin
                if (goStart) begin
                    state_next = sas_pkg::ST_CONV;
                end
            end
            sas_pkg::ST_CONV: begin
                if (clearAll) begin
                    state_next = sas_pkg::ST_IDLE;
                end else if (timerDone) begin
                    state_next = sas_pkg::ST_STORE;
                end
            end
            sas_pkg::ST_STORE: begin
                irq_next = stored;
                if (!clearAll && mode_reg == sas_pkg::MODE_REPEAT) begin
                    state_next = sas_pkg::ST_CONV;
                end else begin
                    state_next = sas_pkg::ST_IDLE;
                end
            end
            default: begin
                state_next = sas_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_reg <= sas_pkg::ST_IDLE;
            irq_reg   <= 1'b0;
        end else if (clkEn) begin
            state_reg <= state_next;
            irq_reg   <= irq_next;
        end
    end

    // read data, one cycle after strobe
    always_comb begin
        rdData_next = sas_pkg::BYTE_ZERO;
        if (regRd) begin
            unique case (regAddr)
                sas_pkg::ADDR_CTRL1: begin
                    rdData_next = {startBit_reg, mode_reg, analog_input_enable_reg, chan_reg};
                end
                sas_pkg::ADDR_STATUS: begin
                    rdData_next = {done_reg, busy, 3'h0, timeCode_reg};
                end
                sas_pkg::ADDR_RES_LO: begin
                    rdData_next = result[7:0];
                end
                sas_pkg::ADDR_RES_HI: begin
                    rdData_next = {6'h00, result[9:8]};
                end
                default: begin
                    rdData_next = sas_pkg::BYTE_ZERO;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdData_reg <= sas_pkg::BYTE_ZERO;
        end else if (clkEn) begin
            rdData_reg <= rdData_next;
        end
    end

    assign regRdData             = rdData_reg;
    assign channelSelect         = chan_reg;
    assign analogInputEnable     = analog_input_enable_reg;
    assign convActive            = (state_reg == sas_pkg::ST_CONV);
    assign conversionCompleteIrq = irq_reg;

    sequence s_start_req;
        (state_reg == sas_pkg::ST_IDLE) && startBit_reg && modeValid && !clearAll;
    endsequence
    sequence s_running;
        busy && !startBit_reg;
    endsequence

    property p_start_busy;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        s_start_req |=> s_running;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("start did not raise busy");

    property p_start_lat;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        (wrCtrl && regWrData[sas_pkg::START_BIT] && !busy && !lowPowerEnter && !modeOffWr
            && regWrData[sas_pkg::MODE_LO]) |=> ##[1:LAT_MAX] convActive;
    endproperty
    a_start_lat: assert property (p_start_lat) else $error("start latency too long");

    property p_done_rd;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        (rdHigh && !stored) |=> !done_reg;
    endproperty
    a_done_rd: assert property (p_done_rd) else $error("upper read kept done");

    property p_single_clr;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        (s_start_req and (mode_reg == sas_pkg::MODE_SINGLE)) |=> !done_reg;
    endproperty
    a_single_clr: assert property (p_single_clr) else $error("single start kept done");

    property p_mode_off;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        clearAll |=> !busy && !done_reg && (result == sas_pkg::RES_ZERO);
    endproperty
    a_mode_off: assert property (p_mode_off) else $error("stop did not clear state");

    property p_store_done;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        stored |=> done_reg && conversionCompleteIrq && (result == $past(sampleIn));
    endproperty
    a_store_done: assert property (p_store_done) else $error("store missed done or irq");

    property p_irq_pulse;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        conversionCompleteIrq |=> !conversionCompleteIrq;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq longer than one cycle");

    property p_stat_zero;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        (regRd && regAddr == sas_pkg::ADDR_STATUS) |=> regRdData[5:3] == 3'h0;
    endproperty
    a_stat_zero: assert property (p_stat_zero) else $error("status bits 5:3 not zero");

    property p_high_zero;
        @(posedge mclk) disable iff (sys_rst || !clkEn)
        rdHigh |=> regRdData[7:2] == 6'h00;
    endproperty
    a_high_zero: assert property (p_high_zero) else $error("upper result bits not zero");

    property p_reset;
        @(posedge mclk) sys_rst |=> !busy && !done_reg && (result == sas_pkg::RES_ZERO);
    endproperty
    a_reset: assert property (p_reset) else $error("reset left state");
endmodule : sas_sequencer

/* tb/sar_adc_sequencer_tb.sv */
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module sar_adc_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;

    // design ports
    logic       mclk;
    logic       sys_rst;
    logic       clkEn;
    logic [7:0] regAddr;
    logic [7:0] regWrData;
    logic       regWr;
    logic       regRd;
    logic [7:0] regRdData;
    logic       lowPowerEnter;
    logic [9:0] sampleIn;
    logic [3:0] channelSelect;
    logic       analogInputEnable;
    logic       convActive;
    logic       conversionCompleteIrq;
    // bench state
    int         n_errors;
    int         checks_done;
    int         irqCount;
    int         runLen;
    int         lastRun;
    int         base;
    int         lens[7] = '{39, 78, 156, 312, 624, 1248, 1248};
    logic [9:0] smp;

    sas_sequencer u_sas_sequencer (
        .mclk                  (mclk),
        .sys_rst               (sys_rst),
        .clkEn                 (clkEn),
        .regAddr               (regAddr),
        .regWrData             (regWrData),
        .regWr                 (regWr),
        .regRd                 (regRd),
        .regRdData             (regRdData),
        .lowPowerEnter         (lowPowerEnter),
        .sampleIn              (sampleIn),
        .channelSelect         (channelSelect),
        .analogInputEnable     (analogInputEnable),
        .convActive            (convActive),
        .conversionCompleteIrq (conversionCompleteIrq)
    );

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // counts interrupt pulses and the length of each counting run
    always @(posedge mclk) begin
        if (conversionCompleteIrq === 1'b1) irqCount++;
        if (convActive === 1'b1) runLen++;
        else if (runLen != 0) begin
            lastRun = runLen;
            runLen = 0;
        end
    end

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge mclk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        #1;
        `CHK(regRdData, exp)
    endtask : rdc

    task automatic wait_irq(input int lim);
        int b;
        int i;
        b = irqCount;
        i = 0;
        while (irqCount == b && i < lim) begin
            @(posedge mclk);
            #1;
            i++;
        end
        `CHK(irqCount, b + 1)
    endtask : wait_irq

    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : idle

    initial begin
        repeat (60000) @(posedge mclk);
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        print_verdict();
    end

    initial begin
        sys_rst = 1'b1;
        clkEn = 1'b1;
        regAddr = 8'h00;
        regWrData = 8'h00;
        regWr = 1'b0;
        regRd = 1'b0;
        lowPowerEnter = 1'b0;
        sampleIn = 10'h000;
        repeat (4) @(posedge mclk);
        sys_rst <= 1'b0;
        // reset values and an unmapped address
        for (int a = 8'h34; a <= 8'h38; a++) rdc(8'(a), 8'h00);
        // time codes 0 to 6, single conversions
        for (int c = 0; c < 7; c++) begin
            smp = 10'h3FF - 10'(c * 37);
            sampleIn <= smp;
            wr(sas_pkg::ADDR_STATUS, 8'h30 | 8'(c));
            wr(sas_pkg::ADDR_CTRL1, 8'hB0 | 8'(c));
            idle(10);
            `CHK(convActive, 1'b1)
            rdc(sas_pkg::ADDR_STATUS, 8'h40 | 8'(c));
            rdc(sas_pkg::ADDR_CTRL1, 8'h30 | 8'(c));
            `CHK(channelSelect, 4'(c))
            `CHK(analogInputEnable, 1'b1)
            wait_irq(lens[c] + 20);
            `CHK(conversionCompleteIrq, 1'b0)
            `CHK(lastRun, lens[c])
            rdc(sas_pkg::ADDR_STATUS, 8'h80 | 8'(c));
            rdc(sas_pkg::ADDR_RES_LO, smp[7:0]);
            rdc(sas_pkg::ADDR_RES_HI, {6'h00, smp[9:8]});
            rdc(sas_pkg::ADDR_STATUS, 8'h00 | 8'(c));
        end
        // restart without reading the upper result
        wr(sas_pkg::ADDR_STATUS, 8'h00);
        wr(sas_pkg::ADDR_CTRL1, 8'hA3);
        wait_irq(60);
        wr(sas_pkg::ADDR_CTRL1, 8'hA3);
        rdc(sas_pkg::ADDR_STATUS, 8'h40);
        wait_irq(60);
        rdc(sas_pkg::ADDR_RES_HI, 8'h03);
        // repeat mode with a completion between the two reads
        sampleIn <= 10'h1C3;
        wr(sas_pkg::ADDR_CTRL1, 8'hE5);
        wait_irq(60);
        `CHK(convActive, 1'b1)
        rdc(sas_pkg::ADDR_RES_LO, 8'hC3);
        sampleIn <= 10'h2D8;
        base = irqCount;
        idle(100);
        `CHK(irqCount, base)
        rdc(sas_pkg::ADDR_RES_HI, 8'h01);
        wait_irq(60);
        rdc(sas_pkg::ADDR_RES_LO, 8'hD8);
        rdc(sas_pkg::ADDR_RES_HI, 8'h02);
        // forced stop in mid conversion
        idle(5);
        wr(sas_pkg::ADDR_CTRL1, 8'h05);
        rdc(sas_pkg::ADDR_STATUS, 8'h00);
        rdc(sas_pkg::ADDR_RES_LO, 8'h00);
        rdc(sas_pkg::ADDR_RES_HI, 8'h00);
        base = irqCount;
        idle(60);
        `CHK(irqCount, base)
        `CHK(convActive, 1'b0)
        // mode 10 with start runs nothing
        wr(sas_pkg::ADDR_CTRL1, 8'hC0);
        idle(5);
        `CHK(convActive, 1'b0)
        rdc(sas_pkg::ADDR_CTRL1, 8'h40);
        // low-power entry during repeat conversions
        wr(sas_pkg::ADDR_CTRL1, 8'hE7);
        wait_irq(60);
        @(posedge mclk);
        lowPowerEnter <= 1'b1;
        @(posedge mclk);
        lowPowerEnter <= 1'b0;
        rdc(sas_pkg::ADDR_STATUS, 8'h00);
        rdc(sas_pkg::ADDR_RES_LO, 8'h00);
        rdc(sas_pkg::ADDR_RES_HI, 8'h00);
        rdc(sas_pkg::ADDR_CTRL1, 8'h07);
        `CHK(analogInputEnable, 1'b0)
        `CHK(convActive, 1'b0)
        print_verdict();
    end
endmodule : sar_adc_sequencer_tb
